//--- bench/pdcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module pdcr_host (
  input  wire logic ref_clk,
  output var  logic spi_sclk,
  output var  logic spi_cs_n,
  output var  logic spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // A bit count other than 32 makes a malformed frame on purpose; a long one wraps round.
  task automatic xfer(input logic [31:1] hi, input logic bad, input int nb, output logic [31:0] rx);
    logic [31:0] f;
    f = {hi, ~^hi ^ bad};
    rx = '0;
    wait_n(1);
    spi_cs_n = 1'b0;
    wait_n(6);
    for (int i = 0; i < nb; i++) begin
      spi_mosi = f[5'(31 - i)];
      wait_n(6);
      spi_sclk = 1'b1;
      rx = {rx[30:0], spi_miso};
      wait_n(6);
      spi_sclk = 1'b0;
    end
    wait_n(6);
    spi_cs_n = 1'b1;
    // The released data line must not keep showing the last bit.
    spi_mosi = ~spi_mosi;
    wait_n(8);
  endtask
endmodule // pdcr_host
`default_nettype wire

//--- bench/pdcr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pdcr_chk
  import pdcr_pkg::*;
(
  input wire logic                       ref_clk,
  input wire logic                       arst_n,
  input wire logic                       spi_cs_n,
  input wire logic                       spi_miso_oe,
  input wire logic                       external_reset_input_n,
  input wire logic                       bridge_one_extended_diag_timer,
  input wire pdcr_cfg_s [NUM_CH-1:0]     chan_cfg,
  input wire pdcr_chan_st_s [NUM_CH-1:0] chan_status,
  input wire logic [NUM_CH-1:0]          diag_time_valid,
  input wire logic [NUM_CH-1:0][1:0]     diag_time_code,
  input wire logic                       bridge_one_current_limit_enable,
  input wire logic                       bridge_one_active_freewheel,
  input wire logic                       gate_current_boost_select,
  input wire logic                       bridge_one_enable,
  input wire logic                       peak_hold_one_enable,
  input wire logic                       frame_error
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  function automatic logic [1:0] raised(logic [1:0] g, logic s);
    if (g == GCC_1) return s ? GCC_20 : GCC_5;
    if (g == GCC_5) return GCC_20;
    return g;
  endfunction

  property p_lim;
    bridge_one_current_limit_enable |-> chan_cfg[IDX_CH3].sense;
  endproperty
  a_lim: assert property (p_lim) else $error("limit enable without shunt sensing");
  property p_diag;
    diag_time_valid == {NUM_CH{!(bridge_one_enable && !bridge_one_extended_diag_timer)}};
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic time valid flag wrong");
  property p_ferr;
    frame_error |-> $stable(chan_cfg) ##1 (!frame_error && $stable(chan_cfg));
  endproperty
  a_ferr: assert property (p_ferr) else $error("bad parity frame changed config");
  property p_oe;
    spi_cs_n [*5] |-> !spi_miso_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("output driven outside frame");
  property p_rst;
    $rose(arst_n) |-> chan_cfg == '0 && diag_time_code == '1 && gate_current_boost_select
      && bridge_one_active_freewheel && !bridge_one_enable && !peak_hold_one_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_stab;
    (spi_cs_n && external_reset_input_n) [*8] |-> $stable({bridge_one_enable, peak_hold_one_enable,
      gate_current_boost_select, bridge_one_active_freewheel, chan_cfg});
  endproperty
  a_stab: assert property (p_stab) else $error("config changed without frame");
  property p_gcc(int i);
    chan_status[i].gate_cur == (chan_status[i].boosted ?
      raised(chan_cfg[i].gcc, gate_current_boost_select) : chan_cfg[i].gcc);
  endproperty
  property p_boost(int i);
    $fell(chan_status[i].boosted) |-> $past(chan_status[i].drive);
  endproperty
  property p_drv(int i);
    chan_status[i].drive |-> $past(chan_cfg[i].enable);
  endproperty
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    a_gcc: assert property (p_gcc(i)) else $error("gate current map wrong");
    a_boost: assert property (p_boost(i)) else $error("boost cleared without turn-off");
    a_drv: assert property (p_drv(i)) else $error("drive while disabled");
  end
  c_ferr: cover property (frame_error);
  c_boost: cover property ($rose(chan_status[IDX_CH3].boosted));
  c_bridge: cover property ($rose(bridge_one_enable));
endmodule // pdcr_chk
`default_nettype wire

//--- bench/test_predriver_channel_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_predriver_channel_config_regs
  import pdcr_pkg::*;
;
  logic                          ref_clk, arst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic                          external_reset_input_n, bridge_one_extended_diag_timer, frame_error;
  logic [NUM_CH-1:0]             channel_control_input, oc_detect, diag_time_valid;
  logic [NUM_CH-1:0][5:0]        actual_thr_code;
  logic [NUM_CH-1:0][1:0]        diag_time_code;
  pdcr_cfg_s [NUM_CH-1:0]        chan_cfg;
  pdcr_chan_st_s [NUM_CH-1:0]    chan_status;
  logic                          bridge_one_current_limit_enable, bridge_one_active_freewheel;
  logic                          gate_current_boost_select, bridge_one_enable;
  logic                          peak_hold_one_mask_report, peak_hold_one_enable;
  logic [26:1]                   ew [NUM_CH];
  logic [31:0]                   eresp, seed, r, q;
  int                            errors, check_count, ferr_n;

  pdcr_config_regs #(.TICK_DIV(1)) pdcr_config_regs_i (.ref_clk, .arst_n, .spi_sclk, .spi_cs_n, .spi_mosi,
    .spi_miso, .spi_miso_oe, .external_reset_input_n, .channel_control_input, .oc_detect, .actual_thr_code,
    .bridge_one_extended_diag_timer, .chan_cfg, .chan_status, .diag_time_code, .diag_time_valid,
    .bridge_one_current_limit_enable, .bridge_one_active_freewheel, .gate_current_boost_select,
    .bridge_one_enable, .peak_hold_one_mask_report, .peak_hold_one_enable, .frame_error);
  pdcr_host pdcr_host_i (.ref_clk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (frame_error === 1'b1) ferr_n++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] resp(logic [3:0] c, logic rw, logic [26:1] w, logic [5:0] t);
    if (w[21]) w[20:15] = t;
    return {c, rw, w, ~^{c, rw, w}};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic chk_regs();
    for (int i = 0; i < NUM_CH; i++) begin
      chk("config", chan_cfg[i], ew[i][21:1]);
      chk("diag time", diag_time_code[i], ew[i][23:22]);
    end
    chk("flags", {bridge_one_current_limit_enable, bridge_one_active_freewheel, gate_current_boost_select,
      bridge_one_enable, peak_hold_one_mask_report, peak_hold_one_enable},
      {ew[1][26] & ew[1][7], ew[1][25:24], ew[2][26:24]});
  endtask
  task automatic frame(input logic [3:0] c, input logic rw, input logic [26:1] w, input logic bad, input int nb);
    logic [31:0] rx;
    int          k;
    int          fe;
    k = int'(c) - 2;
    fe = ferr_n;
    pdcr_host_i.xfer({c, rw, w}, bad, nb, rx);
    chk("response", rx, (nb > 32) ? eresp << (nb - 32) : eresp >> (32 - nb));
    chk("parity error", ferr_n - fe, nb == 32 && bad);
    if (nb == 32) begin
      if (k < 0 || k > 2) eresp = RESP_RST;
      else begin
        if (!rw && !bad) ew[k] = w;
        eresp = resp(c, rw, ew[k], actual_thr_code[k]);
      end
    end
    chk_regs();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    results();
  end

  initial begin
    {errors, check_count, ferr_n} = '0;
    seed = 32'h2c6b3a58;
    {arst_n, channel_control_input, oc_detect, actual_thr_code, bridge_one_extended_diag_timer} = '0;
    external_reset_input_n = 1'b1;
    for (int i = 0; i < NUM_CH; i++) ew[i] = REG_RST[i][26:1];
    eresp = RESP_RST;
    wt(10);
    arst_n = 1'b1;
    wt(3);
    chk_regs();
    for (int c = 2; c <= 4; c++) frame(4'(c), 1'b1, '0, 1'b0, 32);
    frame(4'h3, 1'b0, '1, 1'b1, 32);
    frame(4'h9, 1'b0, '1, 1'b0, 32);
    frame(4'h4, 1'b0, '1, 1'b0, 31);
    frame(4'h2, 1'b0, '1, 1'b0, 33);
    $display("reset and corner test done");
    for (int n = 0; n < 24; n++) begin
      r = rnd();
      q = rnd();
      actual_thr_code = 18'(rnd());
      bridge_one_extended_diag_timer = r[8];
      channel_control_input = r[15:13];
      oc_detect = r[18:16] & r[21:19];
      frame(4'h2 + 4'(r[1:0]), r[4], q[25:0], r[7:5] == 3'h0, r[12:9] == 4'h0 ? 31 : 32);
    end
    $display("random test done");
    external_reset_input_n = 1'b0;
    wt(5);
    external_reset_input_n = 1'b1;
    wt(4);
    for (int i = 0; i < NUM_CH; i++) ew[i] = REG_RST[i][26:1];
    chk_regs();
    $display("external reset test done");
    {channel_control_input, oc_detect} = '0;
    q = '0;
    q[23:22] = 2'h3;
    q[5:4] = GCC_1;
    q[1] = 1'b1;
    frame(4'h3, 1'b0, q[26:1], 1'b0, 32);
    channel_control_input[IDX_CH3] = 1'b1;
    wt(8);
    chk("drive", chan_status[IDX_CH3].drive, 1'b1);
    oc_detect[IDX_CH3] = 1'b1;
    wt(2);
    oc_detect[IDX_CH3] = 1'b0;
    wt(3);
    chk("blanked", {chan_status[IDX_CH3].shutdown, chan_status[IDX_CH3].blanking,
      chan_status[IDX_CH3].no_oc}, 3'h2);
    wt(140);
    chk("no oc", {chan_status[IDX_CH3].blanking, chan_status[IDX_CH3].no_oc}, 2'h1);
    oc_detect[IDX_CH3] = 1'b1;
    wt(3);
    oc_detect[IDX_CH3] = 1'b0;
    chk("trip", {chan_status[IDX_CH3].shutdown, chan_status[IDX_CH3].gate_cur}, {1'b1, GCC_5});
    channel_control_input[IDX_CH3] = 1'b0;
    wt(6);
    channel_control_input[IDX_CH3] = 1'b1;
    wt(8);
    chk("redrive", {chan_status[IDX_CH3].drive, chan_status[IDX_CH3].boosted}, 2'h3);
    channel_control_input[IDX_CH3] = 1'b0;
    wt(8);
    chk("released", {chan_status[IDX_CH3].boosted, chan_status[IDX_CH3].gate_cur}, {1'b0, GCC_1});
    $display("channel test done");
    results();
  end
endmodule // test_predriver_channel_config_regs

bind pdcr_config_regs pdcr_chk pdcr_chk_i (.ref_clk, .arst_n, .spi_cs_n, .spi_miso_oe, .external_reset_input_n,
  .bridge_one_extended_diag_timer, .chan_cfg, .chan_status, .diag_time_valid, .diag_time_code,
  .bridge_one_current_limit_enable, .bridge_one_active_freewheel, .gate_current_boost_select,
  .bridge_one_enable, .peak_hold_one_enable, .frame_error);
`default_nettype wire

//--- logic/pdcr_chan.sv
`timescale 1ns/1ps
`default_nettype none
module pdcr_chan
  import pdcr_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      arst_n,
  input  wire logic      tick,
  input  wire logic      boost_sel,
  input  wire logic      ctrl,
  input  wire logic      oc_detect,
  input  wire logic      diag_read,
  input  wire pdcr_cfg_s cfg,
  output var  pdcr_chan_st_s status
);
  typedef struct packed {
    logic               ctrl_d;
    logic               drive;
    logic               shut;
    logic               diag_seen;
    logic               boost;
    logic [BLANK_W-1:0] blank;
  } pdcr_chan_s;

  pdcr_chan_s st_r, st_nxt;
  logic       on_req;
  logic       blanking;
  logic       oc_ok;
  logic [1:0] gcc_eff;

  assign on_req   = cfg.enable & ctrl;
  assign blanking = (st_r.blank != '0);
  // Drain-source sensing ignores overcurrent while blanking; shunt sensing does not.
  assign oc_ok    = oc_detect & st_r.drive & ~((cfg.sense == SENSE_DS) & blanking);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.ctrl_d = ctrl;
    st_nxt.drive  = on_req & ~st_r.shut & ~oc_ok;
    if (st_nxt.drive & ~st_r.drive) begin
      st_nxt.blank = BLANK_W'(BLANK_NS[cfg.blank] / TICK_NS);
    end else if (tick && blanking) begin
      st_nxt.blank = st_r.blank - BLANK_W'(1);
    end
    if (st_r.shut) begin
      if (diag_read) begin
        st_nxt.diag_seen = 1'b1;
      end
      if (ctrl & ~st_r.ctrl_d && (cfg.reengage == RE_SWITCH || st_r.diag_seen)) begin
        st_nxt.shut      = 1'b0;
        st_nxt.diag_seen = 1'b0;
      end
    end
    // Only a turn-off asked for by the pin or by the enable bit drops the boost,
    // not the protective shutdown itself.
    if (st_r.drive & ~on_req) begin
      st_nxt.boost = 1'b0;
    end
    if (oc_ok) begin
      st_nxt.shut      = 1'b1;
      st_nxt.diag_seen = 1'b0;
      st_nxt.boost     = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    gcc_eff = cfg.gcc;
    if (st_r.boost) begin
      case (cfg.gcc)
        GCC_1:   gcc_eff = boost_sel ? GCC_20 : GCC_5;
        GCC_5:   gcc_eff = GCC_20;
        default: gcc_eff = cfg.gcc;
      endcase
    end
  end

  assign status.drive    = st_r.drive;
  assign status.shutdown = st_r.shut;
  assign status.blanking = blanking;
  assign status.no_oc    = st_r.drive & ~blanking & ~st_r.shut;
  assign status.boosted  = st_r.boost;
  assign status.gate_cur = gcc_eff;
endmodule // pdcr_chan
`default_nettype wire

//--- logic/pdcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pdcr_config_regs
  import pdcr_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC
) (
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  input  wire logic                     spi_sclk,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_mosi,
  output var  logic                     spi_miso,
  output var  logic                     spi_miso_oe,
  input  wire logic                     external_reset_input_n,
  input  wire logic [NUM_CH-1:0]        channel_control_input,
  input  wire logic [NUM_CH-1:0]        oc_detect,
  input  wire logic [NUM_CH-1:0][5:0]   actual_thr_code,
  input  wire logic                     bridge_one_extended_diag_timer,
  output var  pdcr_cfg_s [NUM_CH-1:0]   chan_cfg,
  output var  pdcr_chan_st_s [NUM_CH-1:0] chan_status,
  output var  logic [NUM_CH-1:0][1:0]   diag_time_code,
  output var  logic [NUM_CH-1:0]        diag_time_valid,
  output var  logic                     bridge_one_current_limit_enable,
  output var  logic                     bridge_one_active_freewheel,
  output var  logic                     gate_current_boost_select,
  output var  logic                     bridge_one_enable,
  output var  logic                     peak_hold_one_mask_report,
  output var  logic                     peak_hold_one_enable,
  output var  logic                     frame_error
);
  localparam int SYNC_W = NUM_CH + 4;

  // The divider counter is eight bits wide.
  if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_bad_div
    $error("TICK_DIV must lie between 1 and 256");
  end
  // One stored word per command, from the first to the last command served.
  if (NUM_CH != CMD_LAST - CMD_FIRST + 1) begin : g_bad_ch
    $error("NUM_CH must match the command range");
  end
  // The longest blanking count must fit the channel counter.
  if (BLANK_NS[7] / TICK_NS >= 2 ** BLANK_W) begin : g_bad_blank
    $error("BLANK_W too narrow for the longest blanking time");
  end

  typedef struct packed {
    pdcr_spi_e                  spi;
    logic                       sclk_d;
    logic [5:0]                 cnt;
    logic [31:0]                rx;
    logic [31:0]                tx;
    logic [31:0]                resp;
    logic [NUM_CH-1:0][WORD_MSB:WORD_LSB] word;
    logic [7:0]                 tick_cnt;
    logic                       tick;
    logic [NUM_CH-1:0]          diag_rd;
    logic                       frame_err;
  } pdcr_top_s;

  localparam logic [NUM_CH-1:0][WORD_MSB:WORD_LSB] WORD_RST = {
    REG_RST[IDX_CH4][WORD_MSB:WORD_LSB],
    REG_RST[IDX_CH3][WORD_MSB:WORD_LSB],
    REG_RST[IDX_CH2][WORD_MSB:WORD_LSB]
  };

  localparam pdcr_top_s ST_RST = '{
    spi:       SPI_IDLE,
    sclk_d:    1'b0,
    cnt:       6'h00,
    rx:        32'h00000000,
    tx:        RESP_RST,
    resp:      RESP_RST,
    word:      WORD_RST,
    tick_cnt:  8'h00,
    tick:      1'b0,
    diag_rd:   '0,
    frame_err: 1'b0
  };

  // The chip-select and the external reset pin idle high, so their
  // synchronisers start high to avoid a false frame or reset after power-up.
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {NUM_CH{1'b0}}, 1'b0, 1'b1, 1'b0};

  pdcr_top_s         st_r;
  pdcr_top_s         st_nxt;
  logic [SYNC_W-1:0] pins_s;
  logic              sclk_s;
  logic              cs_n_s;
  logic              mosi_s;
  logic              ext_rst_n_s;
  logic [NUM_CH-1:0] ctrl_s;
  logic              sclk_rise;
  logic              sclk_fall;
  logic [3:0]        rx_cmd;
  logic [1:0]        rx_idx;
  logic              rx_known;
  logic              rx_par_ok;
  logic              rx_read_only;

  pdcr_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RST)
  ) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({external_reset_input_n, channel_control_input, spi_mosi, spi_cs_n, spi_sclk}),
    .q       (pins_s)
  );

  assign sclk_s      = pins_s[0];
  assign cs_n_s      = pins_s[1];
  assign mosi_s      = pins_s[2];
  assign ctrl_s      = pins_s[NUM_CH+2:3];
  assign ext_rst_n_s = pins_s[NUM_CH+3];

  assign sclk_rise = sclk_s & ~st_r.sclk_d;
  assign sclk_fall = ~sclk_s & st_r.sclk_d;

  assign rx_cmd       = st_r.rx[CMD_MSB:CMD_LSB];
  assign rx_known     = (rx_cmd >= CMD_FIRST) && (rx_cmd <= CMD_LAST);
  assign rx_idx       = 2'(rx_cmd - CMD_FIRST);
  assign rx_par_ok    = (st_r.rx[0] == ~^st_r.rx[31:1]);
  assign rx_read_only = st_r.rx[RW_BIT];

  // Builds a readback frame: command, access bit, stored fields with the live threshold code when THR_READ_BIT is set, fresh parity.
  function automatic logic [31:0] build_resp(
    input logic [3:0]             cmd,
    input logic                   rw,
    input logic [WORD_MSB:WORD_LSB] w,
    input logic [5:0]             thr
  );
    logic [31:0] r;
    r = {cmd, rw, w, 1'b0};
    if (w[THR_READ_BIT]) begin
      r[THR_MSB:THR_LSB] = thr;
    end
    r[0] = ~^r[31:1];
    return r;
  endfunction

  always_comb begin
    st_nxt           = st_r;
    st_nxt.tick      = 1'b0;
    st_nxt.diag_rd   = '0;
    st_nxt.frame_err = 1'b0;
    st_nxt.sclk_d    = sclk_s;

    if (st_r.tick_cnt == 8'(TICK_DIV - 1)) begin
      st_nxt.tick_cnt = 8'h00;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
    end

    case (st_r.spi)
      SPI_IDLE: begin
        if (!cs_n_s) begin
          st_nxt.spi = SPI_SHIFT;
          st_nxt.cnt = 6'h00;
          st_nxt.tx  = st_r.resp;
        end
      end
      SPI_SHIFT: begin
        if (cs_n_s) begin
          st_nxt.spi = SPI_IDLE;
          // Frames of any other length are dropped whole; a partial word
          // must never reach the configuration.
          if (st_r.cnt == 6'h20) begin
            if (!rx_par_ok) begin
              st_nxt.frame_err = 1'b1;
            end
            if (rx_known) begin
              if (rx_par_ok && !rx_read_only) begin
                st_nxt.word[rx_idx] = st_r.rx[WORD_MSB:WORD_LSB];
              end
              if (rx_par_ok && rx_read_only) begin
                st_nxt.diag_rd[rx_idx] = 1'b1;
              end
              st_nxt.resp = build_resp(rx_cmd, rx_read_only, st_nxt.word[rx_idx],
                                       actual_thr_code[rx_idx]);
            end else begin
              st_nxt.resp = RESP_RST;
            end
          end
        end else begin
          // Rises past the 32nd keep counting up to 63 and hold there, so an over-long frame is dropped too.
          if (sclk_rise && st_r.cnt != 6'h3f) begin
            st_nxt.cnt = st_r.cnt + 6'h01;
          end
          if (sclk_rise && st_r.cnt < 6'h20) begin
            st_nxt.rx = {st_r.rx[30:0], mosi_s};
          end
          if (sclk_fall) begin
            st_nxt.tx = {st_r.tx[30:0], 1'b0};
          end
        end
      end
      default: begin
        st_nxt.spi = SPI_IDLE;
      end
    endcase

    // The reset pin wins over a frame ending in the same cycle.
    if (!ext_rst_n_s) begin
      st_nxt.word = WORD_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign spi_miso    = st_r.tx[31];
  assign spi_miso_oe = (st_r.spi == SPI_SHIFT);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign chan_cfg[g] = pdcr_cfg_s'(st_r.word[g][CFG_MSB:CFG_LSB]);
      // Bridge one without the extended timer runs its own diagnostic timing.
      assign diag_time_code[g]  = st_r.word[g][DIAG_MSB:DIAG_LSB];
      assign diag_time_valid[g] = ~(bridge_one_enable & ~bridge_one_extended_diag_timer);

      pdcr_chan u_chan (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .tick      (st_r.tick),
        .boost_sel (gate_current_boost_select),
        .ctrl      (ctrl_s[g]),
        .oc_detect (oc_detect[g]),
        .diag_read (st_r.diag_rd[g]),
        .cfg       (chan_cfg[g]),
        .status    (chan_status[g])
      );
    end
  endgenerate

  // Limiting borrows the channel three threshold and only works on a shunt.
  assign bridge_one_current_limit_enable = st_r.word[IDX_CH3][LIMIT_BIT]
                                           & chan_cfg[IDX_CH3].sense;
  assign bridge_one_active_freewheel     = st_r.word[IDX_CH3][FREEWHEEL_BIT];
  assign gate_current_boost_select       = st_r.word[IDX_CH3][BOOST_SEL_BIT];
  assign bridge_one_enable               = st_r.word[IDX_CH4][BRIDGE_EN_BIT];
  assign peak_hold_one_mask_report       = st_r.word[IDX_CH4][PH_MASK_BIT];
  assign peak_hold_one_enable            = st_r.word[IDX_CH4][PH_EN_BIT];
  assign frame_error                     = st_r.frame_err;
endmodule // pdcr_config_regs
`default_nettype wire

//--- logic/pdcr_pkg.sv
`default_nettype none
package pdcr_pkg;
  localparam int CLK_NS   = 10;
  localparam int TICK_NS  = 100;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int NUM_CH   = 3;
  localparam int BLANK_W  = 11;

  localparam int CMD_MSB  = 31;
  localparam int CMD_LSB  = 28;
  localparam int RW_BIT   = 27;
  localparam int WORD_MSB = 26;
  localparam int WORD_LSB = 1;
  localparam int CFG_MSB  = 21;
  localparam int CFG_LSB  = 1;
  localparam int THR_MSB  = 20;
  localparam int THR_LSB  = 15;
  localparam int THR_READ_BIT = 21;
  localparam int DIAG_MSB = 23;
  localparam int DIAG_LSB = 22;

  localparam int LIMIT_BIT     = 26;
  localparam int FREEWHEEL_BIT = 25;
  localparam int BOOST_SEL_BIT = 24;
  localparam int BRIDGE_EN_BIT = 26;
  localparam int PH_MASK_BIT   = 25;
  localparam int PH_EN_BIT     = 24;

  localparam int IDX_CH2 = 0;
  localparam int IDX_CH3 = 1;
  localparam int IDX_CH4 = 2;
  localparam logic [3:0] CMD_FIRST = 4'h2;
  localparam logic [3:0] CMD_LAST  = 4'h4;

  localparam logic [31:0] REG_RST [NUM_CH] = '{32'h2ec00001, 32'h3bc00000, 32'h48c00001};
  localparam logic [31:0] RESP_RST = 32'h00000001;

  localparam int BLANK_NS [8] = '{11100, 15600, 20000, 31100, 42200, 53300, 97800, 142200};

  localparam logic [1:0] GCC_EXT = 2'h0;
  localparam logic [1:0] GCC_20  = 2'h1;
  localparam logic [1:0] GCC_5   = 2'h2;
  localparam logic [1:0] GCC_1   = 2'h3;
  localparam logic       SENSE_DS  = 1'b0;
  localparam logic       RE_SWITCH = 1'b0;

  typedef struct packed {
    logic       thr_read_sel;
    logic [5:0] thr_code;
    logic [1:0] temp_comp;
    logic       batt_comp;
    logic [2:0] blank;
    logic       reengage;
    logic       sense;
    logic       ol_cur;
    logic [1:0] gcc;
    logic       np_sel;
    logic       side;
    logic       enable;
  } pdcr_cfg_s;

  typedef struct packed {
    logic       drive;
    logic       shutdown;
    logic       blanking;
    logic       no_oc;
    logic       boosted;
    logic [1:0] gate_cur;
  } pdcr_chan_st_s;

  typedef enum logic {SPI_IDLE, SPI_SHIFT} pdcr_spi_e;
endpackage
`default_nettype wire

//--- logic/pdcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pdcr_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } st_r, st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= {RST, RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // pdcr_sync
`default_nettype wire
